// ### hdl/halt_sleep_pkg.sv
// constants, register map and carriers for the sleep and gentle-halt command decoder
package halt_sleep_pkg;

  localparam logic [7:0]  DIAG_REQ_ID       = 8'h3C;
  localparam logic [7:0]  SLEEP_FIRST_BYTE  = 8'h00;
  localparam logic [7:0]  BROADCAST_NAD     = 8'h7F;
  localparam logic [7:0]  HALT_CMD_CODE     = 8'h0F;
  localparam logic [10:0] SECURE_DISABLED   = 11'h400;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_ST = 8'h08;
  localparam logic [7:0] OFS_IRQ_MK = 8'h0C;
  localparam logic [7:0] OFS_TARGET = 8'h10;
  localparam logic [7:0] OFS_SECURE = 8'h14;
  localparam logic [7:0] OFS_NAD    = 8'h18;

  // ctrl fields
  localparam int CTRL_SLEEP_PERMIT = 0;
  localparam int CTRL_HALT_REQ     = 1;

  // irq status fields
  localparam int IRQ_SLEEP   = 0;
  localparam int IRQ_STOPPED = 1;
  localparam int IRQ_HALT    = 2;
  localparam int IRQ_HELD    = 3;
  localparam int IRQ_W       = 4;

  localparam logic [7:0]  NAD_RESET    = 8'h01;
  localparam logic [15:0] SECURE_RESET = 16'h0400;
  localparam logic [15:0] TARGET_RESET = 16'h0000;
  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_SLVERR  = 2'b10;

  // one received frame from the link layer, checksum already verified
  typedef struct packed {
    logic       valid;
    logic [7:0] pid;
    logic       classic_ok;
    logic       enhanced_ok;
    logic [7:0] byte1;
    logic [7:0] byte2;
  } frame_t;

  // interface to the positioning ramp generator
  typedef struct packed {
    logic        moving;
    logic        at_vmin;
    logic        dual_pos_busy;
    logic [15:0] actual_position;
  } motion_t;

  typedef enum logic [1:0] {
    ST_IDLE     = 2'b00,
    ST_DECEL    = 2'b01,
    ST_HOLD     = 2'b10,
    ST_SLEEPCHK = 2'b11
  } halt_state_t;

endpackage : halt_sleep_pkg

// ### hdl/halt_sleep_decoder.sv
// go-to-sleep and gentle-halt command decoder with axi4-lite register slave
`timescale 1ns/10ps
module halt_sleep_decoder (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire halt_sleep_pkg::frame_t     frame,
  input  wire logic [7:0]                 pid_addressed,
  input  wire logic [7:0]                 pid_group,
  input  wire halt_sleep_pkg::motion_t    motion,
  input  wire logic                       thermal_shutdown,
  input  wire logic                       third_undervoltage_threshold,
  output logic                            decel_to_vmin,
  output logic                            stop_motion,
  output logic                            sleep_enter,
  output logic                            stopped_state,
  output logic [15:0]                     target_position,
  output logic                            irq,
  input  wire logic [7:0]                 s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [7:0]                 s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready
);
  import halt_sleep_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // register storage

  logic              sleep_permit_bit_reg;
  logic [7:0]        node_nad_reg;
  logic [15:0]       secure_position_reg;
  logic [15:0]       target_reg;
  logic [IRQ_W-1:0]  irq_status_reg;
  logic [IRQ_W-1:0]  irq_mask_reg;
  logic              sw_halt_pulse;
  halt_state_t       state_reg;
  logic              sleep_pending_reg;

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel: address and data taken in either order

  logic [7:0]  aw_addr_reg;
  logic        aw_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        w_held_reg;
  logic        do_write;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;

  // one write in flight: both channels stall while a response waits
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready  = !w_held_reg && !bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign do_write      = aw_held_reg && w_held_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg  <= 1'b0;
      w_held_reg   <= 1'b0;
      aw_addr_reg  <= 8'h00;
      w_data_reg   <= 32'h0000_0000;
      w_strb_reg   <= 4'h0;
      bvalid_reg   <= 1'b0;
      bresp_reg    <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        bvalid_reg   <= 1'b1;
        bresp_reg    <= addr_known(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg   <= 1'b0;
      end
    end
  end

  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == OFS_CTRL) || (a == OFS_STATUS) || (a == OFS_IRQ_ST) ||
                 (a == OFS_IRQ_MK) || (a == OFS_TARGET) || (a == OFS_SECURE) ||
                 (a == OFS_NAD);
  endfunction : addr_known

  function automatic logic wr_hit(input logic [7:0] a);
    wr_hit = do_write && (aw_addr_reg == a);
  endfunction : wr_hit

  // software halt request is a self-clearing write-one bit
  assign sw_halt_pulse = wr_hit(OFS_CTRL) && w_strb_reg[0] && w_data_reg[CTRL_HALT_REQ];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sleep_permit_bit_reg <= 1'b0;
      node_nad_reg         <= NAD_RESET;
      secure_position_reg  <= SECURE_RESET;
      irq_mask_reg         <= '0;
    end else begin
      if (wr_hit(OFS_CTRL) && w_strb_reg[0])
        sleep_permit_bit_reg <= w_data_reg[CTRL_SLEEP_PERMIT];
      if (wr_hit(OFS_NAD) && w_strb_reg[0])
        node_nad_reg <= w_data_reg[7:0];
      if (wr_hit(OFS_SECURE) && w_strb_reg[0])
        secure_position_reg[7:0] <= w_data_reg[7:0];
      if (wr_hit(OFS_SECURE) && w_strb_reg[1])
        secure_position_reg[15:8] <= w_data_reg[15:8];
      if (wr_hit(OFS_IRQ_MK) && w_strb_reg[0])
        irq_mask_reg <= w_data_reg[IRQ_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame decode

  logic is_sleep;
  logic is_halt_nad;
  logic is_halt_group;
  logic halt_trigger;
  logic secure_enabled;

  // fill bytes after byte1 are not looked at
  assign is_sleep = frame.valid && frame.classic_ok && frame.pid == DIAG_REQ_ID &&
                    frame.byte1 == SLEEP_FIRST_BYTE;
  assign is_halt_nad = frame.valid && frame.enhanced_ok && frame.pid == pid_addressed &&
                       frame.byte2 == HALT_CMD_CODE &&
                       (frame.byte1 == node_nad_reg || frame.byte1 == BROADCAST_NAD);
  assign is_halt_group = frame.valid && frame.enhanced_ok && frame.pid == pid_group &&
                         frame.byte1 == HALT_CMD_CODE;
  assign secure_enabled = secure_position_reg[10:0] != SECURE_DISABLED;

  // dual positioning masks every halt source, internal ones included, but not the halt started by a sleep frame with secure position disabled
  assign halt_trigger = !motion.dual_pos_busy &&
                        (is_halt_nad || is_halt_group || sw_halt_pulse ||
                         thermal_shutdown ||
                         third_undervoltage_threshold);

  ////////////////////////////////////////////////////////////////////////////
  // halt and sleep sequencer

  logic start_halt;
  logic sleep_retarget;
  assign sleep_retarget = is_sleep && motion.moving && secure_enabled;
  assign start_halt = (state_reg == ST_IDLE) &&
                      (halt_trigger || (is_sleep && motion.moving && !secure_enabled));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg         <= ST_IDLE;
      sleep_pending_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (start_halt) begin
            state_reg         <= motion.moving ? ST_DECEL : ST_HOLD;
            // a sleep already waiting survives a halt that cuts in
            sleep_pending_reg <= is_sleep || sleep_pending_reg;
          end else if (is_sleep) begin
            state_reg         <= motion.moving ? ST_IDLE : ST_SLEEPCHK;
            sleep_pending_reg <= motion.moving;
          end else if (sleep_pending_reg && !motion.moving) begin
            state_reg <= ST_SLEEPCHK;
          end
        end
        ST_DECEL: begin
          if (!motion.moving)
            state_reg <= ST_HOLD;
        end
        ST_HOLD: begin
          state_reg <= sleep_pending_reg ? ST_SLEEPCHK : ST_IDLE;
        end
        ST_SLEEPCHK: begin
          state_reg         <= ST_IDLE;
          sleep_pending_reg <= 1'b0;
        end
      endcase
    end
  end

  // decel held through the whole ramp-down, stop once vmin is reached
  assign decel_to_vmin = (state_reg == ST_DECEL);
  assign stop_motion   = (state_reg == ST_DECEL) && motion.at_vmin;

  logic sleep_enter_reg;
  logic stopped_state_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sleep_enter_reg   <= 1'b0;
      stopped_state_reg <= 1'b0;
    end else begin
      sleep_enter_reg   <= (state_reg == ST_SLEEPCHK) && sleep_permit_bit_reg;
      stopped_state_reg <= (state_reg == ST_SLEEPCHK) && !sleep_permit_bit_reg;
    end
  end
  assign sleep_enter   = sleep_enter_reg;
  assign stopped_state = stopped_state_reg;

  // target: software write, secure load on sleep, or hold of actual after halt
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      target_reg <= TARGET_RESET;
    end else if (state_reg == ST_HOLD) begin
      target_reg <= motion.actual_position;
    end else if (sleep_retarget && state_reg == ST_IDLE && !halt_trigger) begin
      target_reg <= secure_position_reg;
    end else begin
      if (wr_hit(OFS_TARGET) && w_strb_reg[0])
        target_reg[7:0] <= w_data_reg[7:0];
      if (wr_hit(OFS_TARGET) && w_strb_reg[1])
        target_reg[15:8] <= w_data_reg[15:8];
    end
  end
  assign target_position = target_reg;

  ////////////////////////////////////////////////////////////////////////////
  // interrupts: set wins over write-one clear

  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  assign irq_set = {state_reg == ST_HOLD, start_halt, stopped_state_reg, sleep_enter_reg};
  assign irq_clr = (wr_hit(OFS_IRQ_ST) && w_strb_reg[0]) ? w_data_reg[IRQ_W-1:0] : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn)
      irq_status_reg <= '0;
    else
      irq_status_reg <= (irq_status_reg & ~irq_clr) | irq_set;
  end
  assign irq = |(irq_status_reg & irq_mask_reg);

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (s_axi_araddr)
      OFS_CTRL:   rd_mux[0] = sleep_permit_bit_reg;
      OFS_STATUS: rd_mux[3:0] = {sleep_pending_reg, motion.dual_pos_busy, state_reg};
      OFS_IRQ_ST: rd_mux[IRQ_W-1:0] = irq_status_reg;
      OFS_IRQ_MK: rd_mux[IRQ_W-1:0] = irq_mask_reg;
      OFS_TARGET: rd_mux[15:0] = target_reg;
      OFS_SECURE: rd_mux[15:0] = secure_position_reg;
      OFS_NAD:    rd_mux[7:0] = node_nad_reg;
      default:    rd_mux = 32'h0000_0000;
    endcase
  end

  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;

  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_mux;
      rresp_reg  <= addr_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

endmodule : halt_sleep_decoder

// ### tb/halt_sleep_properties.sv
// assertions on the sleep and gentle-halt decoder ports
`timescale 1ns/10ps
module halt_sleep_properties (
  input wire logic                    aclk,
  input wire logic                    aresetn,
  input wire halt_sleep_pkg::frame_t  frame,
  input wire logic [7:0]              pid_addressed,
  input wire logic [7:0]              pid_group,
  input wire halt_sleep_pkg::motion_t motion,
  input wire logic                    thermal_shutdown,
  input wire logic                    third_undervoltage_threshold,
  input wire logic                    decel_to_vmin,
  input wire logic                    stop_motion,
  input wire logic                    sleep_enter,
  input wire logic                    stopped_state,
  input wire logic [15:0]             target_position
);
  import halt_sleep_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic run, ah, gh, sl;
  // run: moving and free to start a halt
  assign run = motion.moving && !motion.dual_pos_busy && !decel_to_vmin;
  assign ah = frame.valid && frame.pid == pid_addressed && frame.enhanced_ok && frame.byte2 == HALT_CMD_CODE;
  assign gh = frame.valid && frame.pid == pid_group && frame.enhanced_ok && frame.byte1 == HALT_CMD_CODE;
  assign sl = frame.valid && frame.pid == DIAG_REQ_ID && frame.classic_ok && frame.byte1 == SLEEP_FIRST_BYTE;
  //////////////////////////////
  a_stop_at_vmin: assert property (
    stop_motion |-> decel_to_vmin && motion.at_vmin) else $error("stop before vmin");
  a_decel_held: assert property (
    decel_to_vmin && motion.moving |=> decel_to_vmin) else $error("halt dropped early");
  a_broadcast_halt: assert property (
    run && ah && frame.byte1 == BROADCAST_NAD |=> decel_to_vmin) else $error("broadcast halt missed");
  a_group_halt: assert property (
    run && gh |=> decel_to_vmin) else $error("group halt missed");
  a_thermal_halt: assert property (
    run && thermal_shutdown && !frame.valid |=> decel_to_vmin) else $error("thermal halt missed");
  a_uv_halt: assert property (
    run && third_undervoltage_threshold && !frame.valid |=> decel_to_vmin) else $error("uv halt missed");
  a_dual_ignore: assert property (
    motion.moving && motion.dual_pos_busy && !decel_to_vmin && (ah || gh || thermal_shutdown)
    |=> !decel_to_vmin) else $error("halt taken in dual run");
  a_target_held: assert property (
    decel_to_vmin && !motion.moving |=> ##1 target_position == $past(motion.actual_position))
    else $error("stop position lost");
  a_sleep_answer: assert property (
    sl && !motion.moving && !decel_to_vmin |-> ##[1:2] (sleep_enter || stopped_state))
    else $error("sleep frame unanswered");
  a_pulse_single: assert property (
    sleep_enter || stopped_state |-> !(sleep_enter && stopped_state) ##1 !(sleep_enter || stopped_state))
    else $error("bad sleep pulse");
endmodule : halt_sleep_properties

bind halt_sleep_decoder halt_sleep_properties i_halt_sleep_properties (.*);

// ### tb/lin_master_model.sv
// bus master stand-in issuing sleep and gentle-halt frames
`timescale 1ns/10ps
module lin_master_model #(
  parameter logic [7:0] PID_ADDR = 8'h11,
  parameter logic [7:0] PID_GRP  = 8'h22
) (
  input wire logic               aclk,
  output halt_sleep_pkg::frame_t frame
);
  import halt_sleep_pkg::*;
  initial frame = '0;
  //////////////////////////////
  // kind 0 sleep, 1 addressed halt, 2 group halt
  task automatic send(input int kind, input logic [7:0] b1, input logic [7:0] b2);
    @(posedge aclk);
    frame.valid <= 1'b1;
    frame.pid <= (kind == 0) ? DIAG_REQ_ID : (kind == 1) ? PID_ADDR : PID_GRP;
    frame.classic_ok <= (kind == 0);
    frame.enhanced_ok <= (kind != 0);
    frame.byte1 <= b1;
    frame.byte2 <= b2;
    @(posedge aclk);
    // released fields flip so stale bytes never look valid
    frame <= {1'b0, ~frame[25:0]};
  endtask : send
endmodule : lin_master_model

// ### tb/tb.sv
// bench for the sleep and gentle-halt decoder
`timescale 1ns/10ps
module tb;
  import halt_sleep_pkg::*;
  localparam logic [7:0] PA = 8'h11;
  localparam logic [7:0] PG = 8'h22;
  logic        aclk, aresetn, thermal_shutdown, third_undervoltage_threshold;
  logic        decel_to_vmin, stop_motion, sleep_enter, stopped_state, irq;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, x, y;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic [3:0]  s_axi_wstrb;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [15:0] target_position, exp_tgt;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  wire  [7:0]  pid_addressed = PA;
  wire  [7:0]  pid_group = PG;
  frame_t      frame;
  motion_t     motion;
  int          mismatches, comparisons, cycles;
  bit          seen_sl, seen_st;
  halt_sleep_decoder i_halt_sleep_decoder (.*);
  lin_master_model #(.PID_ADDR(PA), .PID_GRP(PG)) i_lin_master_model (.aclk(aclk), .frame(frame));
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      conclude();
    end
  end
  //////////////////////////////
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    y = 1'b0;
    while (!y) begin
      @(negedge aclk);
      x = s_axi_awvalid && s_axi_awready;
      rd[0] = s_axi_wvalid && s_axi_wready;
      y = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge aclk);
      if (x) s_axi_awvalid <= 1'b0;
      if (rd[0]) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    y = 1'b0;
    while (!y) begin
      @(negedge aclk);
      x = s_axi_arvalid && s_axi_arready;
      y = s_axi_rvalid;
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
      if (x) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask : rdr
  task automatic watch();
    seen_sl = 0;
    seen_st = 0;
    repeat (8) begin
      @(negedge aclk);
      seen_sl |= sleep_enter;
      seen_st |= stopped_state;
    end
  endtask : watch
  //////////////////////////////
  initial begin
    {aresetn, thermal_shutdown, third_undervoltage_threshold, motion} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(OFS_NAD);
    chk(rd, 32'h01, "nad reset");
    chk(rs, RESP_OKAY, "read okay");
    rdr(OFS_SECURE);
    chk(rd, 32'h0400, "secure reset");
    rdr(8'h40);
    chk(rs, RESP_SLVERR, "unmapped");
    wr(8'h40, 32'h0000_0001);
    chk(rs, RESP_SLVERR, "unmapped write");
    wr(OFS_IRQ_MK, 32'hF);
    chk(rs, RESP_OKAY, "write okay");
    wr(OFS_TARGET, 32'h0000_1234);
    rdr(OFS_TARGET);
    chk({rd[15:0], target_position}, {16'h1234, 16'h1234}, "target write");
    exp_tgt = 16'h0;
    // 0 own, 1 broadcast, 2 group, 3 thermal, 4 uv, 5 foreign, 6 dual, 7 software request
    for (int k = 0; k < 8; k++) begin
      motion <= {2'b10, k == 6, 16'(256 + k)};
      case (k)
        2: i_lin_master_model.send(2, HALT_CMD_CODE, 8'h00);
        3, 4: begin
          @(posedge aclk) {thermal_shutdown, third_undervoltage_threshold} <= (k == 3) ? 2'b10 : 2'b01;
          @(posedge aclk) {thermal_shutdown, third_undervoltage_threshold} <= 2'b00;
        end
        7: wr(OFS_CTRL, 32'h0000_0003);
        default: i_lin_master_model.send(1, k == 1 ? BROADCAST_NAD : k == 5 ? 8'h33 : NAD_RESET, HALT_CMD_CODE);
      endcase
      @(negedge aclk);
      chk(decel_to_vmin, k < 5 || k == 7, "decel");
      @(posedge aclk) motion.at_vmin <= 1'b1;
      @(negedge aclk);
      chk(stop_motion, k < 5 || k == 7, "stop");
      @(posedge aclk) motion.moving <= 1'b0;
      repeat (4) @(posedge aclk);
      if (k < 5 || k == 7) exp_tgt = 16'(256 + k);
      chk(target_position, exp_tgt, "target");
    end
    chk(irq, 1'b1, "irq");
    rdr(OFS_IRQ_ST);
    chk(rd, 32'hC, "irq status");
    wr(OFS_IRQ_MK, 32'h0);
    @(negedge aclk);
    chk(irq, 1'b0, "irq masked");
    wr(OFS_IRQ_MK, 32'hF);
    wr(OFS_IRQ_ST, 32'hC);
    @(negedge aclk);
    chk(irq, 1'b0, "irq cleared");
    motion <= '0;
    for (int p = 0; p < 2; p++) begin
      wr(OFS_CTRL, p);
      i_lin_master_model.send(0, SLEEP_FIRST_BYTE, 8'h55);
      watch();
      chk({seen_sl, seen_st}, p ? 2'b10 : 2'b01, "sleep outcome");
    end
    wr(OFS_SECURE, 32'h0123);
    motion <= {2'b10, 1'b0, 16'h0200};
    i_lin_master_model.send(0, SLEEP_FIRST_BYTE, 8'hFF);
    repeat (2) @(posedge aclk);
    chk(target_position, 16'h0123, "secure load");
    @(posedge aclk) motion.moving <= 1'b0;
    watch();
    chk(seen_sl, 1'b1, "sleep after move");
    wr(OFS_SECURE, 32'h0400);
    motion <= {2'b10, 1'b0, 16'h0300};
    i_lin_master_model.send(0, SLEEP_FIRST_BYTE, 8'hFF);
    @(negedge aclk);
    chk(decel_to_vmin, 1'b1, "halt before sleep");
    rdr(OFS_STATUS);
    chk(rd, 32'h9, "status pending decel");
    @(posedge aclk) motion <= {2'b01, 1'b0, 16'h0300};
    watch();
    chk({seen_sl, target_position}, {1'b1, 16'h0300}, "sleep after halt");
    rdr(OFS_IRQ_ST);
    chk(rd, 32'hF, "irq all events");
    conclude();
  end
endmodule : tb
